// *** pic_init_asserts.sv ***
// concurrent checks on the controller io bus and its configuration outputs
`timescale 1ns/1ps
module pic_init_asserts #(
    parameter int LINES = 8
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic [LINES-1:0] IRQ_LINES,
    input wire logic INT_OUT,
    input wire logic [4:0] VECTOR_BASE,
    input wire logic CASCADE_EN,
    input wire logic SPECIAL_NESTED,
    input wire logic AUTOMATIC_END_OF_INTERRUPT,
    input wire logic X86_MODE,
    input wire logic [LINES-1:0] PENDING
);
    // ========================================
    // shadow of init position, mask and last write byte
    logic [1:0] step_q;
    logic [7:0] mask_q;
    logic [7:0] wd_q;
    logic odd_wr;
    assign odd_wr = wr && CE && addr == pic_init_pkg::PORT_ODD;
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            step_q <= 2'h0;
        end else if (wr && CE && addr == pic_init_pkg::PORT_EVEN && wdata[pic_init_pkg::INIT1_MARK_BIT]) begin
            step_q <= 2'h1;
        end else if (odd_wr && step_q != 2'h0) begin
            step_q <= (step_q == 2'h3) ? 2'h0 : step_q + 2'h1;
        end
    end
    // re-init leaves the mask alone, so only ready-state writes move it
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            mask_q <= pic_init_pkg::MASK_RESET;
        end else if (odd_wr && step_q == 2'h0) begin
            mask_q <= wdata;
        end
    end
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            wd_q <= 8'h00;
        end else begin
            wd_q <= wdata;
        end
    end
    // ========================================
    // properties
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    a_vector_base_load: assert property (odd_wr && step_q == 2'h1 |=> VECTOR_BASE == wd_q[7:3])
        else $error("vector base not taken");
    a_cascade_load: assert property (odd_wr && step_q == 2'h2 |=> CASCADE_EN == wd_q[2])
        else $error("cascade enable not taken");
    a_nesting_load: assert property (odd_wr && step_q == 2'h3 |=> SPECIAL_NESTED == wd_q[4])
        else $error("nesting select not taken");
    a_automatic_end_of_interrupt_load: assert property (odd_wr && step_q == 2'h3 |=> AUTOMATIC_END_OF_INTERRUPT == wd_q[1])
        else $error("end of interrupt select not taken");
    a_vector_mode_load: assert property (odd_wr && step_q == 2'h3 |=> X86_MODE == wd_q[0])
        else $error("vectoring select not taken");
    a_mask_read: assert property (rd && CE && addr == pic_init_pkg::PORT_ODD && step_q == 2'h0 |=> rdata == mask_q)
        else $error("mask readback wrong");
    a_all_masked: assert property ((mask_q == 8'hFF) [*3] |-> !INT_OUT)
        else $error("interrupt raised while all lines masked");
    a_pending_gate: assert property (($stable(IRQ_LINES) && $stable(mask_q)) [*4] |-> PENDING == (IRQ_LINES & ~mask_q[LINES-1:0]))
        else $error("pending not gated by mask");
    a_int_mid_init: assert property (step_q != 2'h0 |=> !INT_OUT)
        else $error("interrupt raised during init");
    a_rdata_idle: assert property (!(rd && CE && addr == pic_init_pkg::PORT_ODD) |=> rdata == 8'h00)
        else $error("read data not idle outside a read");
endmodule : pic_init_asserts

// *** pic_init_dev.sv ***
// interrupt controller init sequencer, mask and request gating
// Function
// - vector base from upper five bits
// - host writes zero low three bits
// - third word bit 2 enables cascade
// - host zeroes reserved third word bits
// - host zeroes fourth word top bits
// - fourth word bit 4 selects nesting
// - host programs non-buffered mode 00
// - fourth word bit 0 selects vectoring
// - mask bit n gates request line n
// - odd writes follow in order 2,3,4
`timescale 1ns/1ps
module pic_init_dev #(
    parameter int LINES = 8
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic CE,
    pic_io_if.dev BUS,
    input wire logic [LINES-1:0] IRQ_LINES,
    output logic INT_OUT,
    output logic [4:0] VECTOR_BASE,
    output logic CASCADE_EN,
    output logic SPECIAL_NESTED,
    output logic AUTOMATIC_END_OF_INTERRUPT,
    output logic X86_MODE,
    output logic [LINES-1:0] PENDING
);

    // ========================================
    // parameter check
    // mask and init words are one byte, so only eight lines fit
    if (LINES != 8) begin : g_lines_check
        $error("LINES must be 8");
    end

    // ========================================
    // functions
    // one comparator shape for every port decode
    function automatic logic port_hit(input logic strobe, input logic [7:0] addr, input logic [7:0] port);
        return strobe && addr == port;
    endfunction : port_hit

    // a request line counts only while its mask bit is clear
    function automatic logic [LINES-1:0] gate_requests(input logic [LINES-1:0] req, input logic [7:0] mask);
        return req & ~mask[LINES-1:0];
    endfunction : gate_requests

    // ========================================
    // state and storage
    pic_init_pkg::init_state_t state_q;
    logic [7:0] mask_q;
    logic [7:0] vbase_q;
    logic [7:0] casc_q;
    logic [7:0] opt_q;
    logic [7:0] rdata_q;
    logic [LINES-1:0] req_s1_q;
    logic [LINES-1:0] req_s2_q;

    // ========================================
    // bus decode
    logic wr_odd;
    logic wr_init1;
    logic rd_odd;
    logic init_done;

    assign wr_odd = port_hit(BUS.wr, BUS.addr, pic_init_pkg::PORT_ODD);
    assign wr_init1 = port_hit(BUS.wr, BUS.addr, pic_init_pkg::PORT_EVEN) && BUS.wdata[pic_init_pkg::INIT1_MARK_BIT];
    assign rd_odd = port_hit(BUS.rd, BUS.addr, pic_init_pkg::PORT_ODD);
    assign init_done = state_q == pic_init_pkg::ST_READY;

    // ========================================
    // init sequence
    // an even write with the marker bit restarts from any state
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            state_q <= pic_init_pkg::ST_READY;
        end else if (CE) begin
            if (wr_init1) begin
                state_q <= pic_init_pkg::ST_W2;
            end else if (wr_odd) begin
                case (state_q)
                    pic_init_pkg::ST_W2: begin
                        state_q <= pic_init_pkg::ST_W3;
                    end
                    pic_init_pkg::ST_W3: begin
                        state_q <= pic_init_pkg::ST_W4;
                    end
                    pic_init_pkg::ST_W4: begin
                        state_q <= pic_init_pkg::ST_READY;
                    end
                    default: begin
                        state_q <= pic_init_pkg::ST_READY;
                    end
                endcase
            end
        end
    end

    // ========================================
    // vector base word
    // low three bits stored as written; software keeps them zero
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            vbase_q <= pic_init_pkg::OPT_RESET;
        end else if (CE && wr_odd && state_q == pic_init_pkg::ST_W2) begin
            vbase_q <= BUS.wdata;
        end
    end

    // ========================================
    // cascade config word
    // reserved bits stored as written
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            casc_q <= pic_init_pkg::OPT_RESET;
        end else if (CE && wr_odd && state_q == pic_init_pkg::ST_W3) begin
            casc_q <= BUS.wdata;
        end
    end

    // ========================================
    // operating options word
    // buffered mode bits steer nothing; only non-buffered is wired
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            opt_q <= pic_init_pkg::OPT_RESET;
        end else if (CE && wr_odd && state_q == pic_init_pkg::ST_W4) begin
            opt_q <= BUS.wdata;
        end
    end

    // ========================================
    // request mask
    // a new init leaves the mask alone, so blocked lines stay blocked
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            mask_q <= pic_init_pkg::MASK_RESET;
        end else if (CE && wr_odd && init_done) begin
            mask_q <= BUS.wdata;
        end
    end

    // ========================================
    // mask readback, zero outside the read cycle
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            rdata_q <= 8'h00;
        end else if (CE) begin
            rdata_q <= rd_odd ? mask_q : 8'h00;
        end
    end

    assign BUS.rdata = rdata_q;

    // ========================================
    // request synchroniser
    // lines come straight from pins, so two stages before any logic
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            req_s1_q <= '0;
        end else if (CE) begin
            req_s1_q <= IRQ_LINES;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            req_s2_q <= '0;
        end else if (CE) begin
            req_s2_q <= req_s1_q;
        end
    end

    // ========================================
    // pending lines
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            PENDING <= '0;
        end else if (CE) begin
            PENDING <= gate_requests(req_s2_q, mask_q);
        end
    end

    // ========================================
    // interrupt output
    // held low mid-init so a half-programmed vector is never used
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            INT_OUT <= 1'b0;
        end else if (CE) begin
            INT_OUT <= init_done && |gate_requests(req_s2_q, mask_q);
        end
    end

    // ========================================
    // configuration outputs
    // fields are picked straight from the stored words
    assign VECTOR_BASE = vbase_q[7:pic_init_pkg::VBASE_LSB];
    assign CASCADE_EN = casc_q[pic_init_pkg::CASC_BIT];
    assign SPECIAL_NESTED = opt_q[pic_init_pkg::SFN_BIT];
    assign AUTOMATIC_END_OF_INTERRUPT = opt_q[pic_init_pkg::AEOI_BIT];
    assign X86_MODE = opt_q[pic_init_pkg::X86_BIT];

endmodule : pic_init_dev

// *** pic_init_host.sv ***
// host end: software registers to io cycles on the controller bus
`timescale 1ns/1ps
module pic_init_host (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    output logic IRQ,
    pic_io_if.host BUS
);
    logic [1:0] cmd_q;
    logic busy_q;
    logic go;
    logic done;
    logic [7:0] rd_data;
    logic [7:0] data_q;
    logic [7:0] irq_stat_q;
    logic [7:0] irq_en_q;
    // ========================================
    // command: write data reg, then command reg starts the cycle
    // software keeps reserved init bits zero and buffered mode 00
    assign go = CE && WR && ADDR == pic_init_pkg::HREG_CMD && !busy_q;
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            cmd_q <= 2'h0;
            data_q <= 8'h00;
            busy_q <= 1'b0;
        end else if (CE) begin
            if (WR && ADDR == pic_init_pkg::HREG_DATA) data_q <= WDATA;
            if (go) begin
                cmd_q <= WDATA[1:0];
                busy_q <= 1'b1;
            end else if (done) begin
                busy_q <= 1'b0;
            end
        end
    end
    pic_io_master pic_io_master_inst (
        .clk(CORE_CLK),
        .rst(RST),
        .ce(CE),
        .go(go),
        .cmd(WDATA[1:0]),
        .data(data_q),
        .bus(BUS),
        .done(done),
        .rd_data(rd_data)
    );
    // ========================================
    // interrupts: bit0 cycle done; set wins over clear
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            irq_stat_q <= 8'h00;
            irq_en_q <= 8'h00;
        end else if (CE) begin
            if (WR && ADDR == pic_init_pkg::HREG_IRQ_EN) irq_en_q <= WDATA;
            irq_stat_q <= (irq_stat_q & ~((WR && ADDR == pic_init_pkg::HREG_IRQ_CLR) ? WDATA : 8'h00))
                | {7'h00, done};
        end
    end
    assign IRQ = |(irq_stat_q & irq_en_q);
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            RDATA <= 8'h00;
        end else if (CE) begin
            RDATA <= 8'h00;
            if (RD) begin
                case (ADDR)
                    pic_init_pkg::HREG_DATA: RDATA <= data_q;
                    pic_init_pkg::HREG_STAT: RDATA <= {6'h00, cmd_q == pic_init_pkg::CMD_RD_ODD, busy_q};
                    pic_init_pkg::HREG_IRQ_STAT: RDATA <= irq_stat_q;
                    pic_init_pkg::HREG_IRQ_EN: RDATA <= irq_en_q;
                    pic_init_pkg::HREG_RDATA: RDATA <= rd_data;
                    default: RDATA <= 8'h00;
                endcase
            end
        end
    end
endmodule : pic_init_host

// *** pic_init_pkg.sv ***
// shared constants for the interrupt controller init and mask path
package pic_init_pkg;
    // ========================================
    // port map
    localparam logic [7:0] PORT_EVEN = 8'h20;
    localparam logic [7:0] PORT_ODD = 8'h21;
    // ========================================
    // first init word marker and field positions
    localparam int INIT1_MARK_BIT = 4;
    localparam int VBASE_LSB = 3;
    localparam int CASC_BIT = 2;
    localparam int SFN_BIT = 4;
    localparam int AEOI_BIT = 1;
    localparam int X86_BIT = 0;
    localparam logic [7:0] MASK_RESET = 8'hFF;
    localparam logic [7:0] OPT_RESET = 8'h00;
    // ========================================
    // host-side register offsets
    localparam logic [3:0] HREG_CMD = 4'h0;
    localparam logic [3:0] HREG_DATA = 4'h1;
    localparam logic [3:0] HREG_STAT = 4'h2;
    localparam logic [3:0] HREG_IRQ_STAT = 4'h3;
    localparam logic [3:0] HREG_IRQ_CLR = 4'h4;
    localparam logic [3:0] HREG_IRQ_EN = 4'h5;
    localparam logic [3:0] HREG_RDATA = 4'h6;
    // ========================================
    // host commands
    localparam logic [1:0] CMD_WR_EVEN = 2'h0;
    localparam logic [1:0] CMD_WR_ODD = 2'h1;
    localparam logic [1:0] CMD_RD_ODD = 2'h2;
    typedef enum logic [1:0] {ST_READY, ST_W2, ST_W3, ST_W4} init_state_t;
endpackage : pic_init_pkg

// *** pic_io_if.sv ***
// io bus between host and interrupt controller
`timescale 1ns/1ps
interface pic_io_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    modport dev (input addr, input wdata, input wr, input rd, output rdata);
    modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface : pic_io_if

// *** pic_io_master.sv ***
// single-cycle io strobe generator used by the host end
`timescale 1ns/1ps
module pic_io_master (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic go,
    input wire logic [1:0] cmd,
    input wire logic [7:0] data,
    pic_io_if.host bus,
    output logic done,
    output logic [7:0] rd_data
);
    logic rd_pend_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus.addr <= 8'h00;
            bus.wdata <= 8'h00;
            bus.wr <= 1'b0;
            bus.rd <= 1'b0;
        end else if (ce) begin
            bus.wr <= go && cmd != pic_init_pkg::CMD_RD_ODD;
            bus.rd <= go && cmd == pic_init_pkg::CMD_RD_ODD;
            if (go) begin
                bus.addr <= (cmd == pic_init_pkg::CMD_WR_EVEN) ? pic_init_pkg::PORT_EVEN : pic_init_pkg::PORT_ODD;
                bus.wdata <= data;
            end
        end
    end
    // read data one cycle after strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_pend_q <= 1'b0;
            done <= 1'b0;
            rd_data <= 8'h00;
        end else if (ce) begin
            rd_pend_q <= bus.rd;
            done <= bus.wr || rd_pend_q;
            if (rd_pend_q) rd_data <= bus.rdata;
        end
    end
endmodule : pic_io_master

// *** tb_legacy_pic_init_and_mask.sv ***
// self-checking bench: host registers drive the controller over the io bus
`timescale 1ns/1ps
module tb_legacy_pic_init_and_mask;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] irq_lines = 8'h00;
    logic [7:0] rdata, pending, s;
    logic [4:0] vbase;
    logic casc, sfn, aeoi, x86, int_out, irq;
    int error_cnt = 0;
    int comparisons = 0;
    int cyc = 0;
    pic_io_if bus_if ();
    pic_init_dev pic_init_dev_inst (.CORE_CLK(core_clk), .RST(rst), .CE(1'b1), .BUS(bus_if.dev), .IRQ_LINES(irq_lines),
        .INT_OUT(int_out), .VECTOR_BASE(vbase), .CASCADE_EN(casc), .SPECIAL_NESTED(sfn), .AUTOMATIC_END_OF_INTERRUPT(aeoi),
        .X86_MODE(x86), .PENDING(pending));
    pic_init_host pic_init_host_inst (.CORE_CLK(core_clk), .RST(rst), .CE(1'b1), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .IRQ(irq), .BUS(bus_if.host));
    pic_init_asserts #(.LINES(8)) pic_init_asserts_inst (.CORE_CLK(core_clk), .RST(rst), .CE(1'b1), .addr(bus_if.addr),
        .wdata(bus_if.wdata), .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata), .IRQ_LINES(irq_lines),
        .INT_OUT(int_out), .VECTOR_BASE(vbase), .CASCADE_EN(casc), .SPECIAL_NESTED(sfn), .AUTOMATIC_END_OF_INTERRUPT(aeoi),
        .X86_MODE(x86), .PENDING(pending));
    always #25 core_clk = ~core_clk;
    // ========================================
    // hang guard, far above the few hundred cycles needed
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            end_of_test();
        end
    end
    // ========================================
    // bus and compare tasks
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask : reg_wr
    // read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        @(negedge core_clk);
        d = rdata;
    endtask : reg_rd
    task automatic io(input logic [1:0] cmd, input logic [7:0] d);
        logic [7:0] st;
        reg_wr(pic_init_pkg::HREG_DATA, d);
        reg_wr(pic_init_pkg::HREG_CMD, {6'h00, cmd});
        st = 8'h01;
        for (int i = 0; i < 20 && st[0] !== 1'b0; i++) begin
            reg_rd(pic_init_pkg::HREG_STAT, st);
        end
        chk("busy", 8'h00, {7'h00, st[0]});
        chk("last cmd read", {7'h00, cmd == pic_init_pkg::CMD_RD_ODD}, {7'h00, st[1]});
    endtask : io
    // ========================================
    // scenarios
    task automatic t_init(input logic [7:0] v, input logic [7:0] c, input logic [7:0] o);
        io(pic_init_pkg::CMD_WR_EVEN, 8'h11);
        io(pic_init_pkg::CMD_WR_ODD, v);
        io(pic_init_pkg::CMD_WR_ODD, c);
        io(pic_init_pkg::CMD_WR_ODD, o);
        chk("vector base", {3'h0, v[7:3]}, {3'h0, vbase});
        chk("cascade", {7'h00, c[pic_init_pkg::CASC_BIT]}, {7'h00, casc});
        chk("nesting", {7'h00, o[pic_init_pkg::SFN_BIT]}, {7'h00, sfn});
        chk("automatic_end_of_interrupt", {7'h00, o[pic_init_pkg::AEOI_BIT]}, {7'h00, aeoi});
        chk("vectoring", {7'h00, o[pic_init_pkg::X86_BIT]}, {7'h00, x86});
    endtask : t_init
    task automatic t_mask();
        io(pic_init_pkg::CMD_WR_ODD, 8'hA5);
        io(pic_init_pkg::CMD_RD_ODD, 8'h00);
        reg_rd(pic_init_pkg::HREG_RDATA, s);
        chk("mask read", 8'hA5, s);
        @(posedge core_clk);
        irq_lines <= 8'hFF;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        chk("pending", 8'h5A, pending);
        chk("int out", 8'h01, {7'h00, int_out});
        io(pic_init_pkg::CMD_WR_ODD, 8'hFF);
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        chk("masked int out", 8'h00, {7'h00, int_out});
        @(posedge core_clk);
        irq_lines <= 8'h00;
    endtask : t_mask
    // re-init keeps the mask and holds the interrupt low until done
    task automatic t_reinit();
        io(pic_init_pkg::CMD_WR_ODD, 8'h3C);
        @(posedge core_clk);
        irq_lines <= 8'hFF;
        io(pic_init_pkg::CMD_WR_EVEN, 8'h11);
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        chk("int mid-init", 8'h00, {7'h00, int_out});
        chk("pending mid-init", 8'hC3, pending);
        io(pic_init_pkg::CMD_WR_ODD, 8'h20);
        io(pic_init_pkg::CMD_WR_ODD, 8'h00);
        io(pic_init_pkg::CMD_WR_ODD, 8'h01);
        chk("vector base re-init", 8'h04, {3'h0, vbase});
        io(pic_init_pkg::CMD_RD_ODD, 8'h00);
        reg_rd(pic_init_pkg::HREG_RDATA, s);
        chk("mask kept", 8'h3C, s);
        chk("int after init", 8'h01, {7'h00, int_out});
        io(pic_init_pkg::CMD_WR_ODD, 8'hFF);
        @(posedge core_clk);
        irq_lines <= 8'h00;
    endtask : t_reinit
    task automatic t_host_irq();
        reg_wr(pic_init_pkg::HREG_IRQ_CLR, 8'h01);
        reg_wr(pic_init_pkg::HREG_IRQ_EN, 8'h00);
        io(pic_init_pkg::CMD_WR_ODD, 8'hFF);
        reg_rd(pic_init_pkg::HREG_IRQ_STAT, s);
        chk("event flag", 8'h01, {7'h00, s[0]});
        chk("irq disabled", 8'h00, {7'h00, irq});
        reg_wr(pic_init_pkg::HREG_IRQ_EN, 8'h01);
        @(negedge core_clk);
        chk("irq enabled", 8'h01, {7'h00, irq});
        reg_wr(pic_init_pkg::HREG_IRQ_CLR, 8'h01);
        @(negedge core_clk);
        chk("irq cleared", 8'h00, {7'h00, irq});
        // unmapped offset must not start a bus cycle
        reg_wr(4'hF, 8'hFF);
        reg_rd(pic_init_pkg::HREG_STAT, s);
        chk("unmapped busy", 8'h00, {7'h00, s[0]});
    endtask : t_host_irq
    task automatic end_of_test();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        t_init(8'h48, 8'h04, 8'h13);
        t_init(8'hB8, 8'h00, 8'h00);
        t_mask();
        t_reinit();
        t_host_irq();
        end_of_test();
    end
endmodule : tb_legacy_pic_init_and_mask
